// File: common/svid_telemetry_defs.vh
// Register indexes, reset values, link framing and fixed codes of the telemetry bank
`ifndef SVID_TELEMETRY_DEFS_VH
`define SVID_TELEMETRY_DEFS_VH

// Register indexes
`define IDX_MAKER_CODE        8'h00
`define IDX_PRODUCT_CODE      8'h01
`define IDX_REVISION_CODE     8'h02
`define IDX_BUILD_DATE_CODE   8'h03
`define IDX_PROTOCOL_VERSION  8'h05
`define IDX_FEATURE_FLAGS     8'h06
`define IDX_PRIMARY_STATUS    8'h10
`define IDX_SECONDARY_STATUS  8'h11
`define IDX_THERMAL_ZONE      8'h12
`define IDX_OUTPUT_CURRENT    8'h15
`define IDX_OUTPUT_VOLTAGE    8'h16
`define IDX_DIE_TEMPERATURE   8'h17
`define IDX_OUTPUT_POWER      8'h18

// Identity values (arbitrary, neutral)
`define MAKER_CODE_VAL        8'h5a
`define PRODUCT_CODE_VAL      8'h3c
`define REVISION_CODE_VAL     8'h07
`define BUILD_DATE_CODE_VAL   8'h2e

// Fixed and reset values
`define PROTOCOL_VERSION_VAL  8'h02
`define FEATURE_FLAGS_VAL     8'hc7
`define TELEMETRY_RST         8'h01
`define STATUS_RST            8'h00
`define UNSUPPORTED_VAL       8'h00
`define UNMAPPED_VAL          8'h00
`define FULL_SCALE_VAL        8'hff

// Feature flag bit positions
`define FLAG_CURRENT_FORMAT   7
`define FLAG_TEMPERATURE      6
`define FLAG_POWER            2
`define FLAG_VOLTAGE          1
`define FLAG_CURRENT          0

// Link framing
`define FRAME_INDEX_BITS      4'd8
`define FRAME_DATA_BITS       4'd8

`endif

// File: hw/pin_sync.v
// Two-flop synchroniser for inputs arriving from outside the system clock domain
module pin_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
   // Clock and reset
   input  wire             clk,
   input  wire             reset,
   // Asynchronous input and synchronised output
   input  wire [WIDTH-1:0] asyncIn,
   output reg  [WIDTH-1:0] syncOut
);

   reg [WIDTH-1:0] metaQ;

   always @(posedge clk) begin
      if (reset) begin
         metaQ   <= RESET_VAL;
         syncOut <= RESET_VAL;
      end else begin
         metaQ   <= asyncIn;
         syncOut <= metaQ;
      end
   end

endmodule

// File: hw/serial_vid_telemetry_regs.v
// Read-only identification, status and telemetry register bank behind a serial VID link
//
// How it works
// RULE1: Indexes 00h, 01h and 02h return fixed maker, product and revision codes on every read.
// RULE2: Index 05h always returns the protocol version 02h.
// RULE3: The feature flags read C7h: temperature, power, voltage and current measured, inputs not.
// RULE4: Feature flag bit 7 picks the current format, one amp per count or FFh at full scale.
// RULE5: Index 15h holds the 8-bit current reading, reaching FFh at the platform maximum current.
// RULE6: Index 16h holds the sensed output voltage between the sense inputs at 8 mV per count.
// RULE7: Index 17h reports die temperature directly in degrees Celsius, 100 degrees as 64h.
// RULE8: Index 18h holds the 8-bit product of the voltage and current readings.
// RULE9: Temperature or power reading 00h means unsupported, so zero is used for nothing else; the code still loads 00h when a supported reading is zero.
// RULE10: The host reads the primary status at 10h after the alert line is pulled.
// RULE11: Index 11h shows secondary status and index 12h the present thermal zone.
// RULE12: Telemetry registers hold 01h after reset until loaded; status and zone hold 00h.
// RULE13: The alert line is open-drain active low, pulled to ask for a status read.
// RULE14: The platform maximum current is caught from its pin once after reset and then held.
// RULE15: Host writes to any index leave every stored value unchanged.
`include "svid_telemetry_defs.vh"

module serial_vid_telemetry_regs #(
   parameter       CURRENT_FORMAT_SCALED = 1,
   parameter       TEMP_SUPPORTED        = 1,
   parameter       POWER_SUPPORTED       = 1,
   parameter       DATA_WIDTH            = 8,
   parameter [3:0] INDEX_BITS            = `FRAME_INDEX_BITS,
   parameter [3:0] DATA_BITS             = `FRAME_DATA_BITS
) (
   // Clock and reset
   input  wire                  sys_clk,
   input  wire                  reset,
   // Serial link pins
   input  wire                  linkClk,
   input  wire                  sdioIn,
   output reg                   sdioOut,
   output reg                   sdioOeN,
   output wire                  alertOut,
   output wire                  alertOeN,
   // Platform current programming pin
   input  wire [DATA_WIDTH-1:0] current_limit_pin,
   output reg  [DATA_WIDTH-1:0] currentLimitValue,
   // Conversion results
   input  wire                  adcLoad,
   input  wire [DATA_WIDTH-1:0] currentAmps,
   input  wire [DATA_WIDTH-1:0] sense_positive,
   input  wire [DATA_WIDTH-1:0] sense_negative,
   input  wire [DATA_WIDTH-1:0] tempCelsius,
   // Regulator condition
   input  wire                  statusLoad,
   input  wire [DATA_WIDTH-1:0] primaryStatusIn,
   input  wire [DATA_WIDTH-1:0] secondaryStatusIn,
   input  wire [DATA_WIDTH-1:0] thermalZoneIn
);

   localparam [1:0] ST_IDLE  = 2'd0;
   localparam [1:0] ST_INDEX = 2'd1;
   localparam [1:0] ST_WRITE = 2'd2;
   localparam [1:0] ST_READ  = 2'd3;

   wire                  clkSync;
   wire                  sdioSync;
   wire [DATA_WIDTH-1:0] limitSync;
   reg                   clkPrevQ;
   wire                  riseEdge;
   wire                  fallEdge;

   reg  [1:0]            stateQ;
   reg                   writeQ;
   reg                   firstQ;
   reg  [3:0]            bitCntQ;
   reg  [7:0]            indexQ;
   reg  [7:0]            shiftOutQ;
   reg                   limitTakenQ;
   reg  [1:0]            strapWaitQ;

   reg  [7:0]            currentQ;
   reg  [7:0]            voltageQ;
   reg  [7:0]            tempQ;
   reg  [7:0]            powerQ;
   reg  [7:0]            primaryQ;
   reg  [7:0]            secondaryQ;
   reg  [7:0]            zoneQ;
   reg                   alertPendingQ;

   wire [7:0]            featureFlags;
   wire [7:0]            indexNext;
   reg  [7:0]            readData;
   reg  [7:0]            currentD;
   wire [7:0]            voltageD;
   wire [15:0]           powerProduct;
   wire [15:0]           currentScaled;
   wire                  statusRead;

   // Link pins and strap cross into sys_clk
   pin_sync #(.WIDTH(1), .RESET_VAL(1'b1)) clkSyncU (
      .clk     (sys_clk),
      .reset   (reset),
      .asyncIn (linkClk),
      .syncOut (clkSync)
   );

   pin_sync #(.WIDTH(1), .RESET_VAL(1'b1)) sdioSyncU (
      .clk     (sys_clk),
      .reset   (reset),
      .asyncIn (sdioIn),
      .syncOut (sdioSync)
   );

   pin_sync #(.WIDTH(DATA_WIDTH), .RESET_VAL({DATA_WIDTH{1'b0}})) limitSyncU (
      .clk     (sys_clk),
      .reset   (reset),
      .asyncIn (current_limit_pin),
      .syncOut (limitSync)
   );

   always @(posedge sys_clk) begin
      if (reset) begin
         clkPrevQ <= 1'b1;
      end else begin
         clkPrevQ <= clkSync;
      end
   end

   assign riseEdge = clkSync & ~clkPrevQ;
   assign fallEdge = ~clkSync & clkPrevQ;

   // Strap is sampled once the synchroniser has flushed its reset value
   always @(posedge sys_clk) begin
      if (reset) begin
         strapWaitQ        <= 2'd0;
         limitTakenQ       <= 1'b0;
         currentLimitValue <= {DATA_WIDTH{1'b0}};
      end else begin
         // Two edges fill the synchroniser; the third takes the strap
         if (strapWaitQ != 2'd3) begin
            strapWaitQ <= strapWaitQ + 2'd1;
         end
         if (!limitTakenQ && (strapWaitQ == 2'd2)) begin
            limitTakenQ       <= 1'b1; // [RULE14]
            currentLimitValue <= limitSync; // [RULE14]
         end
      end
   end

   assign featureFlags = {(CURRENT_FORMAT_SCALED != 0) ? 1'b1 : 1'b0, // [RULE4]
                          (TEMP_SUPPORTED != 0) ? 1'b1 : 1'b0,
                          3'b000,
                          (POWER_SUPPORTED != 0) ? 1'b1 : 1'b0,
                          2'b11}; // [RULE3]

   // Current scaled so the platform maximum lands on full scale
   assign currentScaled = (currentLimitValue == 8'h00) ? 16'h00ff :
                          (({8'h00, currentAmps} * 16'd255) / {8'h00, currentLimitValue});

   always @* begin
      if (CURRENT_FORMAT_SCALED == 0) begin
         currentD = currentAmps; // [RULE4]
      end else if (currentScaled > 16'h00ff) begin
         currentD = `FULL_SCALE_VAL; // [RULE5]
      end else begin
         currentD = currentScaled[7:0]; // [RULE5]
      end
   end

   // Negative difference clamps at zero rather than wrapping
   assign voltageD = (sense_positive > sense_negative) ?
                     (sense_positive - sense_negative) : 8'h00; // [RULE6]

   // Upper byte of the product keeps the word in eight bits.
   // Built from the values being loaded, so 18h never lags 15h and 16h.
   assign powerProduct = voltageD * currentD; // [RULE8]

   always @(posedge sys_clk) begin
      if (reset) begin
         currentQ <= `TELEMETRY_RST; // [RULE12]
         voltageQ <= `TELEMETRY_RST; // [RULE12]
         tempQ    <= `TELEMETRY_RST; // [RULE12]
         powerQ   <= `TELEMETRY_RST; // [RULE12]
      end else if (adcLoad) begin
         currentQ <= currentD; // [RULE5]
         voltageQ <= voltageD; // [RULE6]
         tempQ    <= (TEMP_SUPPORTED != 0) ? tempCelsius : `UNSUPPORTED_VAL; // [RULE7] [RULE9]
         powerQ   <= (POWER_SUPPORTED != 0) ? powerProduct[15:8] : `UNSUPPORTED_VAL; // [RULE8] [RULE9]
      end
   end

   // Status registers and alert request
   assign indexNext  = {indexQ[6:0], sdioSync};
   assign statusRead = (stateQ == ST_INDEX) && riseEdge && (bitCntQ == INDEX_BITS - 4'd1) &&
                       !writeQ && (indexNext == `IDX_PRIMARY_STATUS);

   always @(posedge sys_clk) begin
      if (reset) begin
         primaryQ      <= `STATUS_RST; // [RULE12]
         secondaryQ    <= `STATUS_RST; // [RULE12]
         zoneQ         <= `STATUS_RST; // [RULE12]
         alertPendingQ <= 1'b0;
      end else begin
         if (statusLoad) begin
            primaryQ   <= primaryStatusIn;
            secondaryQ <= secondaryStatusIn; // [RULE11]
            zoneQ      <= thermalZoneIn; // [RULE11]
         end
         // A change landing with the status read keeps the alert up
         if (statusLoad && (primaryStatusIn != primaryQ)) begin
            alertPendingQ <= 1'b1; // [RULE13]
         end else if (statusRead) begin
            alertPendingQ <= 1'b0; // [RULE10]
         end
      end
   end

   assign alertOut = 1'b0; // [RULE13]
   assign alertOeN = ~alertPendingQ; // [RULE13]

   // Read multiplexer
   always @* begin
      case (indexNext)
         `IDX_MAKER_CODE:       readData = `MAKER_CODE_VAL; // [RULE1]
         `IDX_PRODUCT_CODE:     readData = `PRODUCT_CODE_VAL; // [RULE1]
         `IDX_REVISION_CODE:    readData = `REVISION_CODE_VAL; // [RULE1]
         `IDX_BUILD_DATE_CODE:  readData = `BUILD_DATE_CODE_VAL;
         `IDX_PROTOCOL_VERSION: readData = `PROTOCOL_VERSION_VAL; // [RULE2]
         `IDX_FEATURE_FLAGS:    readData = featureFlags; // [RULE3]
         `IDX_PRIMARY_STATUS:   readData = primaryQ; // [RULE10]
         `IDX_SECONDARY_STATUS: readData = secondaryQ; // [RULE11]
         `IDX_THERMAL_ZONE:     readData = zoneQ; // [RULE11]
         `IDX_OUTPUT_CURRENT:   readData = currentQ; // [RULE5]
         `IDX_OUTPUT_VOLTAGE:   readData = voltageQ; // [RULE6]
         `IDX_DIE_TEMPERATURE:  readData = tempQ; // [RULE7]
         `IDX_OUTPUT_POWER:     readData = powerQ; // [RULE8]
         default:               readData = `UNMAPPED_VAL;
      endcase
   end

   // Frame: start bit 0, direction bit (1 = write), index MSB first, then 8 data bits.
   // Device changes SDIO on falling link edges; host samples on rising ones.
   always @(posedge sys_clk) begin
      if (reset) begin
         stateQ    <= ST_IDLE;
         writeQ    <= 1'b0;
         firstQ    <= 1'b1;
         bitCntQ   <= 4'd0;
         indexQ    <= 8'h00;
         shiftOutQ <= 8'h00;
         sdioOut   <= 1'b1;
         sdioOeN   <= 1'b1;
      end else begin
         firstQ <= 1'b0;
         case (stateQ)
            ST_IDLE: begin
               sdioOeN <= 1'b1;
               if (riseEdge && !sdioSync) begin
                  stateQ  <= ST_INDEX;
                  firstQ  <= 1'b1;
                  bitCntQ <= 4'd0;
               end
            end
            ST_INDEX: begin
               if (riseEdge) begin
                  if (firstQ) begin
                     writeQ <= sdioSync;
                  end else begin
                     indexQ  <= indexNext;
                     bitCntQ <= bitCntQ + 4'd1;
                     if (bitCntQ == INDEX_BITS - 4'd1) begin
                        bitCntQ   <= 4'd0;
                        shiftOutQ <= readData;
                        stateQ    <= writeQ ? ST_WRITE : ST_READ;
                     end
                  end
               end else begin
                  firstQ <= firstQ;
               end
            end
            ST_WRITE: begin
               // Data bits are clocked past and dropped
               if (riseEdge) begin
                  bitCntQ <= bitCntQ + 4'd1; // [RULE15]
                  if (bitCntQ == DATA_BITS - 4'd1) begin
                     stateQ <= ST_IDLE; // [RULE15]
                  end
               end
            end
            ST_READ: begin
               if (fallEdge) begin
                  if (bitCntQ == DATA_BITS) begin
                     sdioOeN <= 1'b1;
                     sdioOut <= 1'b1;
                     stateQ  <= ST_IDLE;
                  end else begin
                     sdioOeN <= 1'b0;
                     sdioOut <= shiftOutQ[7];
                  end
               end else if (riseEdge && !sdioOeN) begin
                  shiftOutQ <= {shiftOutQ[6:0], 1'b0};
                  bitCntQ   <= bitCntQ + 4'd1;
               end
            end
            default: begin
               stateQ <= ST_IDLE;
            end
         endcase
      end
   end

endmodule

// File: test/host_link_model.sv
// Host end of the serial link: clock, data pin with pull-up, frame task
module host_link_model (
   // Clock
   input  wire  clk,
   // Device side of the data pin
   input  wire  sdioOut,
   input  wire  sdioOeN,
   // Wires seen by the device
   output logic linkClk,
   output wire  sdioWire
);
   timeunit 1ns;
   timeprecision 1ns;
   logic hostDrive;
   logic hostBit;
   // Released line floats to the pull-up level
   assign sdioWire = !sdioOeN ? sdioOut : (hostDrive ? hostBit : 1'b1);
   initial begin
      linkClk = 1'b1;
      hostDrive = 1'b0;
      hostBit = 1'b1;
   end
   // Four clk per phase; sampled late in the high phase, clear of the device's sync lag
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wdat,
      output logic [7:0] rdat);
      logic [17:0] bits;
      bits = {1'b0, wr, idx, wdat};
      rdat = 8'h00;
      for (int i = 0; i < 19; i++) begin
         @(posedge clk);
         linkClk <= 1'b0;
         hostDrive <= (i < 10) || (wr && i < 18);
         hostBit <= (i < 18) ? bits[17-i] : 1'b1;
         repeat (4) @(posedge clk);
         linkClk <= 1'b1;
         repeat (3) @(posedge clk);
         #1;
         if (i >= 10 && i < 18) rdat[17-i] = sdioWire;
      end
   endtask
endmodule

// File: test/serial_vid_telemetry_regs_assertions.sv
// Port-level checks for the telemetry register bank
module svid_regs_checker #(
   parameter DATA_WIDTH = 8
) (
   // Clock and reset
   input wire                  sys_clk,
   input wire                  reset,
   // Link and alert pins
   input wire                  linkClk,
   input wire                  sdioOut,
   input wire                  sdioOeN,
   input wire                  alertOut,
   input wire                  alertOeN,
   // Strap and status
   input wire [DATA_WIDTH-1:0] current_limit_pin,
   input wire [DATA_WIDTH-1:0] currentLimitValue,
   input wire                  statusLoad,
   input wire [DATA_WIDTH-1:0] primaryStatusIn
);
   reg [3:0]            relCnt_q;
   reg [DATA_WIDTH-1:0] lastSt_q;
   // Edges since release, saturating so the strap window is seen once
   always @(posedge sys_clk) begin
      if (reset) begin
         relCnt_q <= 4'h0;
         lastSt_q <= {DATA_WIDTH{1'b0}};
      end else begin
         if (relCnt_q != 4'hf) relCnt_q <= relCnt_q + 4'h1;
         if (statusLoad) lastSt_q <= primaryStatusIn;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_alert_drain: assert property (alertOut == 1'b0)
      else $error("alert pin value not low");
   a_alert_on_change: assert property (statusLoad && primaryStatusIn != lastSt_q |=> !alertOeN)
      else $error("alert not raised on status change");
   a_alert_cause: assert property ($fell(alertOeN) |-> $past(statusLoad))
      else $error("alert raised without status load");
   a_limit_capture: assert property (relCnt_q == 4'h6 |-> currentLimitValue == current_limit_pin)
      else $error("strap value not captured");
   a_limit_held: assert property (relCnt_q > 4'h6 |-> $stable(currentLimitValue))
      else $error("captured strap changed");
   a_drive_after_fall: assert property ($fell(sdioOeN) |-> $past(linkClk, 3) == 1'b0)
      else $error("data driven outside low clock phase");
   a_bit_on_low: assert property (!sdioOeN && $changed(sdioOut) |-> $past(linkClk, 3) == 1'b0)
      else $error("data bit changed while link clock high");
   a_window_held: assert property ($fell(sdioOeN) |-> !sdioOeN [*8])
      else $error("read data window cut short");
   a_window_ends: assert property ($fell(sdioOeN) |-> ##[60:70] sdioOeN)
      else $error("read data window not released");
   cover property (!alertOeN);
   cover property ($fell(sdioOeN));
   cover property (relCnt_q == 4'h6);
endmodule

bind serial_vid_telemetry_regs svid_regs_checker #(.DATA_WIDTH(DATA_WIDTH)) chk_u (
   .sys_clk(sys_clk), .reset(reset), .linkClk(linkClk), .sdioOut(sdioOut), .sdioOeN(sdioOeN),
   .alertOut(alertOut), .alertOeN(alertOeN), .current_limit_pin(current_limit_pin),
   .currentLimitValue(currentLimitValue), .statusLoad(statusLoad),
   .primaryStatusIn(primaryStatusIn));

// File: test/testbench.sv
// Self-checking bench for the telemetry register bank
`include "svid_telemetry_defs.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] LIMIT = 8'hc8;
   logic       sys_clk, reset, adcLoad, statusLoad;
   logic [7:0] currentAmps, sensePos, senseNeg, tempC, st1, st2, zone, rd, limitPin;
   logic [7:0] expCur, expVolt, expTemp, expPow;
   wire        linkClk, sdioWire, sdioOut, sdioOeN, alertOut, alertOeN;
   wire  [7:0] limitVal;
   int         errors, cmp_count, seed, a, b;

   serial_vid_telemetry_regs dut_u (
      .sys_clk(sys_clk), .reset(reset), .linkClk(linkClk), .sdioIn(sdioWire),
      .sdioOut(sdioOut), .sdioOeN(sdioOeN), .alertOut(alertOut), .alertOeN(alertOeN),
      .current_limit_pin(limitPin), .currentLimitValue(limitVal), .adcLoad(adcLoad),
      .currentAmps(currentAmps), .sense_positive(sensePos), .sense_negative(senseNeg),
      .tempCelsius(tempC), .statusLoad(statusLoad), .primaryStatusIn(st1),
      .secondaryStatusIn(st2), .thermalZoneIn(zone));
   host_link_model host_u (
      .clk(sys_clk), .sdioOut(sdioOut), .sdioOeN(sdioOeN), .linkClk(linkClk),
      .sdioWire(sdioWire));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   function automatic logic [7:0] expect_reg(input logic [7:0] idx);
      case (idx)
         `IDX_MAKER_CODE: return `MAKER_CODE_VAL;
         `IDX_PRODUCT_CODE: return `PRODUCT_CODE_VAL;
         `IDX_REVISION_CODE: return `REVISION_CODE_VAL;
         `IDX_BUILD_DATE_CODE: return `BUILD_DATE_CODE_VAL;
         `IDX_PROTOCOL_VERSION: return 8'h02;
         `IDX_FEATURE_FLAGS: return 8'hc7;
         `IDX_PRIMARY_STATUS: return st1;
         `IDX_SECONDARY_STATUS: return st2;
         `IDX_THERMAL_ZONE: return zone;
         `IDX_OUTPUT_CURRENT: return expCur;
         `IDX_OUTPUT_VOLTAGE: return expVolt;
         `IDX_DIE_TEMPERATURE: return expTemp;
         `IDX_OUTPUT_POWER: return expPow;
         default: return 8'h00;
      endcase
   endfunction

   // Full-scale format: FFh at the strapped limit, clipped above it
   function automatic logic [7:0] scale_cur(input logic [7:0] amps);
      int s;
      s = amps * 255 / LIMIT;
      return (s > 255) ? 8'hff : 8'(s);
   endfunction

   task automatic read_span(input int first, input int count);
      for (int i = first; i < first + count; i++) begin
         host_u.xfer(1'b0, 8'(i), 8'h00, rd);
         check(rd, expect_reg(8'(i)));
      end
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   initial begin
      seed = 54;
      errors = 0;
      cmp_count = 0;
      reset = 1'b1;
      {adcLoad, statusLoad} = 2'b00;
      {currentAmps, sensePos, senseNeg, tempC, st1, st2, zone} = 56'h0;
      {expCur, expVolt, expTemp, expPow} = {4{8'h01}};
      limitPin = LIMIT;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      repeat (8) @(posedge sys_clk);
      check(limitVal, LIMIT);
      // Strap moves after capture; the held value must not follow it
      limitPin <= 8'($random(seed));
      read_span(0, 25);
      // First pass pins the corners: current at the limit, 100 degrees
      for (int n = 0; n < 6; n++) begin
         a = {$random(seed)} % 100;
         b = {$random(seed)} % 100;
         @(posedge sys_clk);
         currentAmps <= (n == 0) ? LIMIT : 8'(13 + {$random(seed)} % 243);
         senseNeg <= 8'(a);
         sensePos <= 8'(a + 16 + b);
         tempC <= (n == 0) ? 8'h64 : 8'(1 + {$random(seed)} % 255);
         adcLoad <= 1'b1;
         @(posedge sys_clk);
         adcLoad <= 1'b0;
         expCur = scale_cur(currentAmps);
         expVolt = sensePos - senseNeg;
         expTemp = tempC;
         expPow = 8'((16'(expVolt) * expCur) >> 8);
         read_span(8'h15, 4);
      end
      // Third load repeats the old value, so no alert is due
      for (int n = 0; n < 3; n++) begin
         @(posedge sys_clk);
         st1 <= (n == 2) ? st1 : st1 + 8'(1 + {$random(seed)} % 254);
         st2 <= 8'($random(seed));
         zone <= 8'($random(seed));
         statusLoad <= 1'b1;
         @(posedge sys_clk);
         statusLoad <= 1'b0;
         repeat (3) @(posedge sys_clk);
         check(alertOeN, n == 2);
         read_span(8'h10, 3);
         check(alertOeN, 1'b1);
      end
      for (int i = 0; i < 25; i++) host_u.xfer(1'b1, 8'(i), 8'($random(seed)), rd);
      read_span(0, 25);
      check(limitVal, LIMIT);
      finish_test();
   end
endmodule
